// file: dv/smbus_slave_register_port_test.sv
// self-checking bench for the serial register port
`timescale 1ns/100ps
`default_nettype none
module smbus_slave_register_port_test;
  import ssp_pkg::*;
  localparam int TO = 200;
  localparam logic [6:0] ADR = 7'h4c;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic rate_tick = 1'b0;
  logic conv_done = 1'b0;
  wire scl, sda, sda_out, oe_n, mon_en, conv_start, lp_wait, run_mode;
  int n_errors = 0;
  int checked = 0;
  int n_starts = 0;
  ssp_port #(.ADDR_SEL(2'h0), .TIMEOUT(TO)) dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_serial_clock_pin(scl),
    .i_serial_data_pin(sda), .i_rate_tick(rate_tick),
    .i_convert_done(conv_done), .o_serial_data_pin(sda_out),
    .o_serial_data_pin_oe_n(oe_n), .o_monitor_enable(mon_en),
    .o_convert_start(conv_start), .o_low_power_wait(lp_wait),
    .o_run_mode(run_mode));
  ssp_host_model host (.i_clock(i_clock), .i_dev_oe_n(oe_n),
    .o_scl(scl), .o_sda(sda));
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (conv_start === 1'b1) n_starts++;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_clk
  task automatic wr_reg(input logic [7:0] cmd, dat);
    logic [2:0] a;
    host.start();
    host.wr_byte({ADR, 1'b0}, a[0]);
    host.wr_byte(cmd, a[1]);
    host.wr_byte(dat, a[2]);
    host.stop();
    check(a, 3'h7, "write acks");
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] cmd, exp);
    logic [2:0] a;
    logic [7:0] d;
    host.start();
    host.wr_byte({ADR, 1'b0}, a[0]);
    host.wr_byte(cmd, a[1]);
    host.start();
    host.wr_byte({ADR, 1'b1}, a[2]);
    host.rd_byte(1'b1, d);
    host.stop();
    check(a, 3'h7, "read acks");
    check(d, exp, "read data");
  endtask : rd_reg
  task automatic set_ptr(input logic [7:0] cmd);
    logic [1:0] a;
    host.start();
    host.wr_byte({ADR, 1'b0}, a[0]);
    host.wr_byte(cmd, a[1]);
    host.stop();
    check(a, 2'h3, "send acks");
  endtask : set_ptr
  task automatic recv(input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    host.start();
    host.wr_byte({ADR, 1'b1}, a);
    host.rd_byte(1'b1, d);
    host.stop();
    check(a, 1'b1, "receive ack");
    check(d, exp, "receive data");
  endtask : recv
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({oe_n, run_mode, mon_en, lp_wait}, 4'h8, "reset outs");
    check(sda_out, 1'b0, "data pin level");
  endtask : t_reset
  // back-to-back writes, then the read command leaves the pointer set
  task automatic t_write_read();
    wr_reg(8'h20, 8'ha5);
    wr_reg(8'h21, 8'h3c);
    rd_reg(8'h20, 8'ha5);
    rd_reg(8'h21, 8'h3c);
    recv(8'h3c);
  endtask : t_write_read
  task automatic t_pointer();
    set_ptr(8'h20);
    recv(8'ha5);
    recv(8'ha5);
  endtask : t_pointer
  task automatic t_foreign();
    logic [2:0] a;
    for (int k = 1; k < 4; k++) begin
      host.start();
      host.wr_byte({ADR + 7'(k), 1'b0}, a[0]);
      host.wr_byte(8'h20, a[1]);
      host.wr_byte(8'h00, a[2]);
      host.stop();
      check(a, 3'h0, "foreign acks");
    end
    rd_reg(8'h20, 8'ha5);
  endtask : t_foreign
  task automatic t_one_shot();
    int n0;
    n0 = n_starts;
    wr_reg(ONE_SHOT_ADDR, 8'h01);
    wait_clk(3);
    check(8'(n_starts - n0), 8'h01, "one-shot starts");
    check({mon_en, run_mode}, 2'h2, "one-shot mode");
    conv_done = 1'b1;
    wait_clk(1);
    conv_done = 1'b0;
    wait_clk(3);
    check({mon_en, run_mode}, 2'h0, "back in standby");
  endtask : t_one_shot
  task automatic t_run();
    int n0;
    n0 = n_starts;
    wr_reg(CFG_ADDR, 8'h00);
    wait_clk(3);
    check({run_mode, mon_en, lp_wait}, 3'h7, "run idle");
    rate_tick = 1'b1;
    wait_clk(1);
    rate_tick = 1'b0;
    wait_clk(3);
    check(8'(n_starts - n0), 8'h01, "run starts");
    check(lp_wait, 1'b0, "busy wait");
    conv_done = 1'b1;
    wait_clk(1);
    conv_done = 1'b0;
    wait_clk(3);
    check(lp_wait, 1'b1, "wait again");
    wr_reg(CFG_ADDR, 8'h40);
    wait_clk(3);
    check({run_mode, mon_en}, 2'h0, "standby again");
  endtask : t_run
  // silence while the port drives a data bit of 0x3c
  task automatic t_timeout();
    logic a;
    set_ptr(8'h21);
    host.start();
    host.wr_byte({ADR, 1'b1}, a);
    wait_clk(8);
    check(oe_n, 1'b0, "driving msb");
    wait_clk(TO + 20);
    check(oe_n, 1'b1, "timed out");
    host.wr_byte({ADR, 1'b1}, a);
    check(a, 1'b0, "no start ack");
    host.stop();
    recv(8'h3c);
  endtask : t_timeout
  initial begin
    #400_000;
    n_errors++;
    complete_run();
  end
  initial begin
    wait_clk(16);
    i_rst = 1'b0;
    t_reset();
    wait_clk(4);
    t_write_read();
    t_pointer();
    t_foreign();
    t_one_shot();
    t_run();
    t_timeout();
    complete_run();
  end
endmodule : smbus_slave_register_port_test
`default_nettype wire

// file: dv/ssp_host_model.sv
// host controller model that masters the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module ssp_host_model (
  input wire logic i_clock,
  input wire logic i_dev_oe_n,
  output logic o_scl,
  output wire logic o_sda
);
  // half bit in clocks; well above the port's sync and drive delay
  localparam int HALF = 10;
  logic drv = 1'b1;
  initial o_scl = 1'b1;
  // open drain: pulled up unless a party pulls low
  assign o_sda = drv & i_dev_oe_n;
  task automatic gap(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : gap
  // data moves only while the clock is low, a few clocks after the fall
  task automatic bit_io(input logic b, output logic s);
    gap(3);
    drv = b;
    gap(HALF);
    o_scl = 1'b1;
    gap(HALF);
    s = o_sda;
    o_scl = 1'b0;
  endtask : bit_io
  task automatic start();
    gap(3);
    drv = 1'b1;
    gap(HALF);
    o_scl = 1'b1;
    gap(HALF);
    drv = 1'b0;
    gap(HALF);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    gap(3);
    drv = 1'b0;
    gap(HALF);
    o_scl = 1'b1;
    gap(HALF);
    drv = 1'b1;
    gap(HALF);
  endtask : stop
  // msb first, ninth bit released to read the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask : rd_byte
endmodule : ssp_host_model
`default_nettype wire

// file: hw/ssp_pkg.sv
// constants and types for the serial management register port
package ssp_pkg;

  // ---------------------------------------------------------------
  // clock and timeout
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int TIMEOUT_MS = 25;
  // 25 ms of bus silence, rounded down to whole cycles
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
  localparam int TIMEOUT_W = 22;

  // ---------------------------------------------------------------
  // slave address options, one chosen per build (values arbitrary)
  // ---------------------------------------------------------------
  localparam logic [27:0] ADDR_OPTIONS = {7'h4f, 7'h4e, 7'h4d, 7'h4c};
  localparam int ADDR_W = 7;

  // ---------------------------------------------------------------
  // byte registers steering the power mode
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR = 8'h03;
  localparam int CFG_STANDBY_BIT = 6;
  localparam logic CFG_STANDBY_RESET = 1'b1;
  localparam logic [7:0] ONE_SHOT_ADDR = 8'h0f;

  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD      = 4'h2,
    ST_CMD_ACK  = 4'h6,
    ST_DATA     = 4'h7,
    ST_DATA_ACK = 4'h5,
    ST_TX       = 4'h4,
    ST_TX_ACK   = 4'hc,
    ST_IGNORE   = 4'h8
  } ssp_state_e;

  typedef enum logic [1:0] {
    PM_STANDBY  = 2'h0,
    PM_RUN      = 2'h1,
    PM_ONE_SHOT = 2'h3
  } ssp_pmode_e;

endpackage : ssp_pkg

// file: hw/ssp_port.sv
// slave-only two-wire register port with run and standby power modes
//
// How it works
// - write byte: address+write, command, data, each acked; data stored.
// - read byte: address+write, command, repeated start, address+read, data out.
// - send byte: command loads the pointer, no register content changes.
// - receive byte: ack, return pointed register, pointer left unchanged.
// - slave only; never starts a transaction.
// - foreign address or bad protocol: no ack, no drive, registers untouched.
// - one fixed slave address per build, chosen from four.
// - tolerate clock held low by others; never hold clock ourselves.
// - after 25 ms bus silence, abandon transfer, go idle, release data.
// - run mode: monitors on, conversions start at programmed rate.
// - run mode between conversions: reduced-power wait state.
// - power-up in standby: monitoring off, no conversions.
// - standby keeps the serial port fully working.
// - one-shot write in standby: one conversion set, back to standby.
`timescale 1ns/100ps
`default_nettype none
module ssp_port
  import ssp_pkg::*;
#(
  parameter logic [1:0] ADDR_SEL = 2'h0,
  parameter int TIMEOUT = TIMEOUT_CYCLES,
  parameter int REG_DEPTH = 256
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_serial_clock_pin,
  input wire logic i_serial_data_pin,
  input wire logic i_rate_tick,
  input wire logic i_convert_done,
  output logic o_serial_data_pin,
  output logic o_serial_data_pin_oe_n,
  output logic o_monitor_enable,
  output logic o_convert_start,
  output logic o_low_power_wait,
  output logic o_run_mode
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SLAVE_ADDR =
    ADDR_OPTIONS[ADDR_SEL*ADDR_W +: ADDR_W];

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    ssp_state_e st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic we;
    logic [7:0] wdata;
    logic drive_low;
    logic sda_oe_n;
    logic [TIMEOUT_W-1:0] idle_cnt;
    ssp_pmode_e pm;
    logic standby;
    logic converting;
    logic conv_start;
    logic lp_wait;
    logic run_mode;
  } ssp_state_s;

  ssp_state_s s_reg;
  ssp_state_s s_next;
  logic [7:0] rdata;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic bus_edge;
  logic byte_done;
  logic timed_out;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  ssp_regmem #(
    .DEPTH(REG_DEPTH),
    .AW(8)
  ) u_mem (
    .i_clock(i_clock),
    .i_we(s_reg.we),
    .i_waddr(s_reg.ptr),
    .i_wdata(s_reg.wdata),
    .i_raddr(s_reg.ptr),
    .o_rdata(rdata)
  );

  // ---------------------------------------------------------------
  // bus events, seen only through the second synchroniser stage
  // ---------------------------------------------------------------
  assign scl_rise = s_reg.scl_s2 & ~s_reg.scl_d;
  assign scl_fall = ~s_reg.scl_s2 & s_reg.scl_d;
  assign bus_start = s_reg.scl_s2 & s_reg.scl_d & s_reg.sda_d &
                     ~s_reg.sda_s2;
  assign bus_stop = s_reg.scl_s2 & s_reg.scl_d & ~s_reg.sda_d &
                    s_reg.sda_s2;
  assign bus_edge = (s_reg.scl_s2 ^ s_reg.scl_d) |
                    (s_reg.sda_s2 ^ s_reg.sda_d);
  assign byte_done = (s_reg.cnt == BIT_COUNT_BYTE);
  assign timed_out = (s_reg.idle_cnt == TIMEOUT_W'(TIMEOUT - 1)) &
                     ~bus_edge;

  always_comb begin
    s_next = s_reg;
    s_next.scl_s1 = i_serial_clock_pin;
    s_next.scl_s2 = s_reg.scl_s1;
    s_next.scl_d = s_reg.scl_s2;
    s_next.sda_s1 = i_serial_data_pin;
    s_next.sda_s2 = s_reg.sda_s1;
    s_next.sda_d = s_reg.sda_s2;
    s_next.we = 1'b0;
    s_next.conv_start = 1'b0;

    // clock may sit low up to the timeout; the silence count restarts on any bus edge and while idle
    if (bus_edge || s_reg.st == ST_IDLE) begin
      s_next.idle_cnt = '0;
    end else begin
      s_next.idle_cnt = s_reg.idle_cnt + TIMEOUT_W'(1);
    end

    if (bus_start) begin
      s_next.st = ST_ADDR;
      s_next.cnt = '0;
      s_next.drive_low = 1'b0;
    end else if (bus_stop || timed_out) begin
      // idle waits for a fresh start before decoding again
      s_next.st = ST_IDLE;
      s_next.drive_low = 1'b0;
      s_next.idle_cnt = '0;
    end else if (scl_rise) begin
      case (s_reg.st)
        ST_ADDR, ST_CMD, ST_DATA: begin
          s_next.shift = {s_reg.shift[6:0], s_reg.sda_s2};
          s_next.cnt = s_reg.cnt + 4'h1;
        end
        ST_TX_ACK: begin
          s_next.st = ST_IGNORE; // one byte only, then wait for stop
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (s_reg.st)
        ST_ADDR: begin
          if (byte_done && s_reg.shift[7:1] == SLAVE_ADDR) begin
            s_next.st = ST_ADDR_ACK;
            s_next.drive_low = 1'b1;
          end else if (byte_done) begin
            s_next.st = ST_IGNORE;
          end
        end
        ST_ADDR_ACK: begin
          s_next.cnt = 4'h1;
          if (s_reg.shift[0]) begin
            // pointer is not touched by a read
            s_next.st = ST_TX;
            s_next.drive_low = ~rdata[7];
            s_next.tx = {rdata[6:0], 1'b1};
          end else begin
            s_next.st = ST_CMD;
            s_next.cnt = '0;
            s_next.drive_low = 1'b0;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            s_next.ptr = s_reg.shift;
            s_next.st = ST_CMD_ACK;
            s_next.drive_low = 1'b1;
          end
        end
        ST_CMD_ACK: begin
          s_next.st = ST_DATA;
          s_next.cnt = '0;
          s_next.drive_low = 1'b0;
        end
        ST_DATA: begin
          if (byte_done) begin
            s_next.we = 1'b1;
            s_next.wdata = s_reg.shift;
            s_next.st = ST_DATA_ACK;
            s_next.drive_low = 1'b1;
          end
        end
        ST_DATA_ACK: begin
          // further bytes are not a supported protocol
          s_next.st = ST_IGNORE;
          s_next.drive_low = 1'b0;
        end
        ST_TX: begin
          if (byte_done) begin
            s_next.st = ST_TX_ACK;
            s_next.drive_low = 1'b0;
          end else begin
            s_next.drive_low = ~s_reg.tx[7];
            s_next.tx = {s_reg.tx[6:0], 1'b1};
            s_next.cnt = s_reg.cnt + 4'h1;
          end
        end
        default: begin
          s_next.drive_low = 1'b0;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // power modes
    // ---------------------------------------------------------------
    if (s_reg.we && s_reg.ptr == CFG_ADDR) begin
      s_next.standby = s_reg.wdata[CFG_STANDBY_BIT];
    end
    if (i_convert_done) begin
      s_next.converting = 1'b0;
    end
    case (s_reg.pm)
      PM_STANDBY: begin
        if (s_reg.we && s_reg.ptr == ONE_SHOT_ADDR) begin
          s_next.pm = PM_ONE_SHOT;
          s_next.conv_start = 1'b1;
          s_next.converting = 1'b1;
        end else if (!s_next.standby) begin
          s_next.pm = PM_RUN;
        end
      end
      PM_ONE_SHOT: begin
        if (i_convert_done) begin
          s_next.pm = s_next.standby ? PM_STANDBY : PM_RUN;
        end
      end
      PM_RUN: begin
        if (s_next.standby && !s_reg.converting) begin
          s_next.pm = PM_STANDBY;
        end else if (i_rate_tick && !s_reg.converting) begin
          s_next.conv_start = 1'b1;
          s_next.converting = 1'b1;
        end
      end
      default: begin
        s_next.pm = PM_STANDBY;
      end
    endcase
    // quiet between conversion sets while running
    s_next.lp_wait = (s_next.pm == PM_RUN) && !s_next.converting;
    s_next.run_mode = (s_next.pm == PM_RUN);
    s_next.sda_oe_n = ~s_next.drive_low;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_reg <= '0;
      s_reg.scl_s1 <= 1'b1;
      s_reg.scl_s2 <= 1'b1;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_s1 <= 1'b1;
      s_reg.sda_s2 <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.st <= ST_IDLE;
      s_reg.pm <= PM_STANDBY;
      s_reg.standby <= CFG_STANDBY_RESET;
      s_reg.sda_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs; open-drain data only ever pulled low, no clock driver
  // ---------------------------------------------------------------
  assign o_serial_data_pin = 1'b0;
  assign o_serial_data_pin_oe_n = s_reg.sda_oe_n;
  assign o_monitor_enable = s_reg.pm[0]; // bit 0 set in run and one-shot only
  assign o_convert_start = s_reg.conv_start;
  assign o_low_power_wait = s_reg.lp_wait;
  assign o_run_mode = s_reg.run_mode;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence addr_match_s;
    s_reg.st == ST_ADDR && scl_fall && !bus_start && !bus_stop &&
      !timed_out && byte_done && s_reg.shift[7:1] == SLAVE_ADDR;
  endsequence
  sequence one_shot_req_s;
    s_reg.pm == PM_STANDBY && s_reg.we && s_reg.ptr == ONE_SHOT_ADDR;
  endsequence
  foreign_quiet_a: assert property (s_reg.st == ST_IGNORE |->
    o_serial_data_pin_oe_n) else $error("data driven while ignoring traffic");

  addr_ack_a: assert property (addr_match_s |=>
    s_reg.st == ST_ADDR_ACK && !o_serial_data_pin_oe_n)
    else $error("own address not acknowledged");

  timeout_idle_a: assert property (timed_out && !bus_start &&
    s_reg.st != ST_IDLE |=> s_reg.st == ST_IDLE && o_serial_data_pin_oe_n)
    else $error("timeout did not release the bus");

  ptr_load_a: assert property (s_reg.st == ST_CMD && scl_fall &&
    byte_done && !bus_start && !bus_stop && !timed_out |=>
      s_reg.ptr == $past(s_reg.shift))
    else $error("command byte did not load pointer");

  data_store_a: assert property (s_reg.st == ST_DATA && scl_fall &&
    byte_done && !bus_start && !bus_stop && !timed_out |=> s_reg.we &&
      s_reg.wdata == $past(s_reg.shift) ##1 !s_reg.we)
    else $error("data byte not stored exactly once");

  read_ptr_a: assert property (s_reg.st == ST_TX ||
    s_reg.st == ST_TX_ACK |=> $stable(s_reg.ptr))
    else $error("pointer moved during a read");

  no_write_read_a: assert property (s_reg.st == ST_ADDR_ACK |->
    !s_reg.we) else $error("register written outside a data byte");

  standby_boot_a: assert property ($past(i_rst) && !i_rst |->
    s_reg.pm == PM_STANDBY && !o_monitor_enable && !o_convert_start)
    else $error("not in standby after reset");

  one_shot_a: assert property (one_shot_req_s |=> o_convert_start &&
    s_reg.pm == PM_ONE_SHOT ##1 !o_convert_start)
    else $error("one-shot did not start one conversion set");

  run_wait_a: assert property (o_convert_start |-> !o_low_power_wait)
    else $error("wait state during a conversion");

endmodule : ssp_port
`default_nettype wire

// file: hw/ssp_regmem.sv
// byte register storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module ssp_regmem #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : ssp_regmem
`default_nettype wire
